// >>> hw/spl_top.sv
// Self-programming control: section blocking, lock programming and
// fuse/lock readback, with an AHB-Lite register slave.
// Assumes the core reports each store and load instruction as a one-cycle
// strobe and performs the ordinary flash read itself when not substituted.
//
// Our own choices: the AHB-Lite register port and the register offsets.

// Function
// - Block reads of the readable-while-write section during erase or write.
// - Busy flag stays set while that section is busy or blocked.
// - Software re-enables the section; the re-enable write clears busy.
// - Pattern X0001001 then store instruction within four cycles sets locks.
// - Only the boot lock bits can be programmed by the store path.
// - Each zero among R0 bits 5..2 programs its boot lock bit.
// - Lock programming never blocks any flash section.
// - Pending EEPROM write refuses programming and fuse or lock reads.
// - Pointer 0001 with lock-set and enable returns the lock byte.
// - Enable bits clear after the read or when the windows lapse.
// - With both bits clear the load instruction reads flash normally.
// - Lock byte: boot locks in bits 5..2, lock bits in 1..0.
// - Pointer 0000 returns the fuse low byte.
// - Pointer 0003 returns the fuse high byte.
// - Programmed bits read as zero, unprogrammed bits as one.
// - A flash operation runs to completion through a system reset.
// - Each operation lasts between 3.7 ms and 4.5 ms.
// - Control writes other than five legal low patterns are ignored.
// - Enable opens a four-cycle window and stays high during operations.
module spl_top #(
   parameter int unsigned OP_CYCLES = spl_pkg::OP_MIN_CYC
) (
   input wire logic clk_sys_i,              // system clock, 25 MHz
   input wire logic rst_b_i,                // system reset, active low
   input wire logic por_b_i,                // power-on reset, active low
   input wire logic ce_i,                   // clock enable
   input wire logic hsel_i,                 // AHB select
   input wire logic [31:0] haddr_i,         // AHB address
   input wire logic [1:0] htrans_i,         // AHB transfer type
   input wire logic hwrite_i,               // AHB write
   input wire logic [2:0] hsize_i,          // AHB size, words only
   input wire logic [31:0] hwdata_i,        // AHB write data
   input wire logic hready_i,               // AHB bus ready
   output logic [31:0] hrdata_o,            // AHB read data
   output logic hreadyout_o,                // AHB slave ready
   output logic hresp_o,                    // AHB response
   input wire spl_pkg::spl_spm_t spm_i,     // store instruction strobe
   input wire spl_pkg::spl_lpm_t lpm_i,     // load instruction strobe
   output spl_pkg::spl_lpm_rsp_t lpm_rsp_o, // load result
   input wire logic eeprom_write_active_i,  // EEPROM write pending
   input wire logic [7:0] fuse_low_i,       // fuse low byte levels
   input wire logic [7:0] fuse_high_i,      // fuse high byte levels
   input wire logic [1:0] lock_lo_i,        // lock_bit_2, lock_bit_1
   output logic rww_block_o                 // rww_busy_flag and read block
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   spl_pkg::spl_state_t st;
   logic [4:0] ctrl;
   logic [3:0] boot_lock;
   logic [3:0] lock_mask;
   logic wr_pend;
   logic [31:0] wr_addr;
   logic spm_open;
   logic lpm_open;
   logic op_busy;
   logic op_done;

   // ----------------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------------
   wire addr_take = hsel_i & htrans_i[1] & hready_i;
   wire wr_ctrl = wr_pend & (wr_addr == spl_pkg::ADDR_CTRL);
   wire [4:0] cmd = hwdata_i[4:0];
   wire ee_blk = eeprom_write_active_i;
   wire idle = (st == spl_pkg::ST_IDLE);
   wire cmd_ok = wr_ctrl & spl_pkg::cmd_legal(cmd) & !ee_blk & idle;
   wire reen = cmd_ok & (cmd == spl_pkg::CMD_REEN);
   wire arm = cmd_ok & !reen;
   wire spm_take = spm_i.exec & spm_open & ctrl[spl_pkg::CTRL_SPM_EN] &
      !ee_blk & idle;
   wire page_go = spm_take &
      (ctrl[spl_pkg::CTRL_ERASE] | ctrl[spl_pkg::CTRL_WRITE]);
   wire lock_go = spm_take & ctrl[spl_pkg::CTRL_LOCKSET];
   wire rd_armed = ctrl[spl_pkg::CTRL_LOCKSET] & ctrl[spl_pkg::CTRL_SPM_EN];
   wire z_lo = (lpm_i.z == spl_pkg::Z_FUSE_LO);
   wire z_lk = (lpm_i.z == spl_pkg::Z_LOCK);
   wire z_hi = (lpm_i.z == spl_pkg::Z_FUSE_HI);
   wire lock_rd = lpm_i.exec & lpm_open & rd_armed & !ee_blk &
      (z_lo | z_lk | z_hi);
   wire ctrl_clr = spm_take | lock_rd | !spm_open;
   wire [7:0] lock_byte = {2'b11, boot_lock, lock_lo_i};
   wire [7:0] lpm_byte = z_lk ? lock_byte :
      (z_hi ? fuse_high_i : fuse_low_i);
   wire [7:0] ctrl_view = {1'b0, rww_block_o, 1'b0, ctrl[4:1],
      ctrl[spl_pkg::CTRL_SPM_EN] | !idle};
   wire [7:0] stat_view = {5'h00, ee_blk, st == spl_pkg::ST_LOCK,
      st == spl_pkg::ST_PAGE};
   wire [31:0] rd_data = (haddr_i == spl_pkg::ADDR_CTRL) ?
      {24'h000000, ctrl_view} : (haddr_i == spl_pkg::ADDR_STAT) ?
      {16'h0000, lock_byte, stat_view} : 32'h0000_0000;

   // ----------------------------------------------------------------------
   // Windows and operation timer
   // ----------------------------------------------------------------------
   spl_window #(.N(spl_pkg::SPM_WIN_CYC)) u_spm_win (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .start_i(arm),
      .cancel_i(spm_take | lock_rd),
      .open_o(spm_open)
   );

   spl_window #(.N(spl_pkg::LPM_WIN_CYC)) u_lpm_win (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .start_i(arm),
      .cancel_i(spm_take | lock_rd),
      .open_o(lpm_open)
   );

   spl_op_timer #(.CYCLES(OP_CYCLES)) u_timer (
      .clk_sys_i(clk_sys_i),
      .por_b_i(por_b_i),
      .ce_i(ce_i),
      .start_i(page_go | lock_go),
      .busy_o(op_busy),
      .done_o(op_done)
   );

   // ----------------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         wr_pend <= 1'b0;
         wr_addr <= '0;
         hrdata_o <= '0;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end else if (ce_i) begin
         wr_pend <= addr_take & hwrite_i;
         if (addr_take) begin
            wr_addr <= haddr_i;
            hrdata_o <= rd_data;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Control bits and load results
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         ctrl <= spl_pkg::CTRL_RST;
         lpm_rsp_o <= '0;
      end else if (ce_i) begin
         if (arm) begin
            ctrl <= cmd;
         end else if (ctrl_clr) begin
            ctrl <= spl_pkg::CTRL_RST;
         end
         lpm_rsp_o.valid <= lpm_i.exec;
         lpm_rsp_o.special <= lock_rd;
         lpm_rsp_o.data <= lock_rd ? lpm_byte : 8'h00;
      end
   end

   // ----------------------------------------------------------------------
   // Operation sequencer, kept through a system reset
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!por_b_i) begin
         st <= spl_pkg::ST_IDLE;
         rww_block_o <= 1'b0;
         boot_lock <= spl_pkg::BOOT_LOCK_RST;
         lock_mask <= spl_pkg::BOOT_LOCK_RST;
      end else if (ce_i) begin
         case (st)
            spl_pkg::ST_IDLE: begin
               if (page_go) begin
                  st <= spl_pkg::ST_PAGE;
                  rww_block_o <= 1'b1;
               end else if (lock_go) begin
                  st <= spl_pkg::ST_LOCK;
                  lock_mask <= spm_i.r0[5:2];
               end else if (reen) begin
                  rww_block_o <= 1'b0;
               end
            end
            spl_pkg::ST_PAGE: begin
               if (op_done) begin
                  st <= spl_pkg::ST_IDLE;
               end
            end
            spl_pkg::ST_LOCK: begin
               if (op_done) begin
                  boot_lock <= boot_lock & lock_mask;
                  st <= spl_pkg::ST_IDLE;
               end
            end
            default: begin
               st <= spl_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   localparam int unsigned OPW = $clog2(OP_CYCLES + 1) + 1;
   logic [OPW-1:0] op_len;

   always_ff @(posedge clk_sys_i) begin
      if (!por_b_i) begin
         op_len <= '0;
      end else if (ce_i) begin
         if (page_go | lock_go) begin
            op_len <= OPW'(1);
         end else if (op_busy) begin
            op_len <= op_len + OPW'(1);
         end
      end
   end

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i || !por_b_i);

   sequence s_armed;
      ce_i && arm ##1 (ce_i && !spm_i.exec && !lpm_i.exec && !wr_pend)[*4];
   endsequence

   a_page_blocks: assert property (
      ce_i && page_go |=> rww_block_o && st == spl_pkg::ST_PAGE)
      else $error("page operation did not block the section");
   a_busy_page: assert property (
      st == spl_pkg::ST_PAGE |-> rww_block_o && ctrl_view[6])
      else $error("busy flag low during page operation");
   a_reen_clears: assert property (
      ce_i && reen && idle |=> !rww_block_o ##1 !ctrl_view[6])
      else $error("re-enable did not clear busy");
   a_reen_ignored: assert property (
      ce_i && wr_ctrl && cmd == spl_pkg::CMD_REEN && !idle |=> rww_block_o
      || !$past(rww_block_o))
      else $error("re-enable acted during operation");
   a_lock_start: assert property (
      ce_i && lock_go |=> st == spl_pkg::ST_LOCK && op_busy)
      else $error("lock write did not start");
   a_lock_only: assert property (
      ce_i && st == spl_pkg::ST_LOCK && op_done |=> lock_byte[7:6] == 2'b11
      && lock_byte[1:0] == $past(lock_lo_i))
      else $error("non-boot lock bits changed");
   a_lock_apply: assert property (
      ce_i && st == spl_pkg::ST_LOCK && op_done |=>
      boot_lock == ($past(boot_lock) & $past(lock_mask)))
      else $error("boot lock bits not programmed from mask");
   a_lock_no_block: assert property (
      st == spl_pkg::ST_LOCK && $past(st) != spl_pkg::ST_PAGE |->
      rww_block_o == $past(rww_block_o))
      else $error("lock write changed section blocking");
   a_ee_refuse: assert property (
      ce_i && ee_blk && lpm_i.exec |=> !lpm_rsp_o.special && idle ==
      $past(idle))
      else $error("access accepted during EEPROM write");
   a_lock_read: assert property (
      ce_i && lock_rd && z_lk |=> lpm_rsp_o.special &&
      lpm_rsp_o.data == {2'b11, $past(boot_lock), $past(lock_lo_i)})
      else $error("lock byte read wrong");
   a_read_clears: assert property (
      ce_i && lock_rd |=> ctrl == spl_pkg::CTRL_RST)
      else $error("bits not cleared after read");
   a_win_lapse: assert property (
      s_armed ##1 ce_i && !spm_i.exec && !wr_pend |=> ctrl == '0)
      else $error("bits not cleared after window");
   a_win_holds: assert property (
      s_armed |-> ctrl != '0 && spm_open)
      else $error("window closed too early");
   a_plain_load: assert property (
      ce_i && lpm_i.exec && !rd_armed |=> lpm_rsp_o.valid &&
      !lpm_rsp_o.special)
      else $error("load substituted without enable");
   a_fuse_lo: assert property (
      ce_i && lock_rd && z_lo |=> lpm_rsp_o.data == $past(fuse_low_i))
      else $error("fuse low byte wrong");
   a_fuse_hi: assert property (
      ce_i && lock_rd && z_hi |=> lpm_rsp_o.data == $past(fuse_high_i))
      else $error("fuse high byte wrong");
   a_reset_keeps_op: assert property (
      @(posedge clk_sys_i) disable iff (!por_b_i)
      !rst_b_i && ce_i && st == spl_pkg::ST_PAGE && !op_done |=>
      st == spl_pkg::ST_PAGE && rww_block_o)
      else $error("system reset aborted operation");
   a_op_length: assert property (
      ce_i && op_done |-> op_len == OPW'(OP_CYCLES))
      else $error("operation length out of range");
   a_cmd_filter: assert property (
      ce_i && wr_ctrl && !spl_pkg::cmd_legal(cmd) |=> !$rose(spm_open))
      else $error("illegal pattern accepted");
   a_spm_high: assert property (
      !idle |-> ctrl_view[0])
      else $error("enable low during operation");

endmodule : spl_top

// >>> common/spl_pkg.sv
// Constants, types and decode functions of the self-programming block.
// Assumes a 25 MHz system clock and a bus master using whole-word transfers.
package spl_pkg;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned OP_MIN_NS = 3_700_000;
   localparam int unsigned OP_MAX_NS = 4_500_000;
   localparam int unsigned OP_MIN_CYC =
      (OP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OP_MAX_CYC = OP_MAX_NS / CLK_PERIOD_NS;
   localparam int unsigned SPM_WIN_CYC = 4;
   localparam int unsigned LPM_WIN_CYC = 3;

   // ----------------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------------
   localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
   localparam logic [31:0] ADDR_STAT = 32'h0000_0004;
   localparam int unsigned CTRL_SPM_EN = 0;
   localparam int unsigned CTRL_ERASE = 1;
   localparam int unsigned CTRL_WRITE = 2;
   localparam int unsigned CTRL_LOCKSET = 3;
   localparam int unsigned CTRL_REEN = 4;
   localparam int unsigned CTRL_BUSY = 6;
   localparam logic [4:0] CTRL_RST = 5'h00;
   localparam logic [3:0] BOOT_LOCK_RST = 4'hf;

   // ----------------------------------------------------------------------
   // Command patterns and pointer values
   // ----------------------------------------------------------------------
   localparam logic [4:0] CMD_REEN = 5'h11;
   localparam logic [4:0] CMD_LOCKSET = 5'h09;
   localparam logic [4:0] CMD_WRITE = 5'h05;
   localparam logic [4:0] CMD_ERASE = 5'h03;
   localparam logic [4:0] CMD_LOAD = 5'h01;
   localparam logic [15:0] Z_FUSE_LO = 16'h0000;
   localparam logic [15:0] Z_LOCK = 16'h0001;
   localparam logic [15:0] Z_FUSE_HI = 16'h0003;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_PAGE, ST_LOCK} spl_state_t;

   typedef struct packed {
      logic exec;
      logic [7:0] r0;
   } spl_spm_t;

   typedef struct packed {
      logic exec;
      logic [15:0] z;
   } spl_lpm_t;

   typedef struct packed {
      logic valid;
      logic special;
      logic [7:0] data;
   } spl_lpm_rsp_t;

   // Only these low-five-bit patterns have any effect when written.
   function automatic logic cmd_legal(input logic [4:0] cmd);
      cmd_legal = (cmd == CMD_REEN) || (cmd == CMD_LOCKSET) ||
         (cmd == CMD_WRITE) || (cmd == CMD_ERASE) || (cmd == CMD_LOAD);
   endfunction : cmd_legal

endpackage : spl_pkg

// >>> hw/spl_window.sv
// Countdown window that stays open for N enabled cycles after a start.
// Assumes start and cancel are single-cycle strobes from the owner.
module spl_window #(
   parameter int unsigned N = 4
) (
   input wire logic clk_sys_i, // system clock
   input wire logic rst_b_i,   // synchronous reset, active low
   input wire logic ce_i,      // clock enable
   input wire logic start_i,   // open the window
   input wire logic cancel_i,  // close the window early
   output logic open_o         // window open
);
   localparam int unsigned W = $clog2(N + 1);
   localparam logic [W-1:0] LOAD = W'(N);

   logic [W-1:0] cnt;

   assign open_o = (cnt != '0);

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         cnt <= '0;
      end else if (ce_i) begin
         if (start_i) begin
            cnt <= LOAD;
         end else if (cancel_i) begin
            cnt <= '0;
         end else if (open_o) begin
            cnt <= cnt - W'(1);
         end
      end
   end

endmodule : spl_window

// >>> hw/spl_op_timer.sv
// Fixed-length timer for flash erase, write and lock programming.
// Assumes it is cleared only at power-on so a running operation survives
// a system reset.
module spl_op_timer #(
   parameter int unsigned CYCLES = spl_pkg::OP_MIN_CYC
) (
   input wire logic clk_sys_i, // system clock
   input wire logic por_b_i,   // power-on reset, active low
   input wire logic ce_i,      // clock enable
   input wire logic start_i,   // begin one operation
   output logic busy_o,        // operation running
   output logic done_o         // last cycle of the operation
);
   localparam int unsigned W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LOAD = W'(CYCLES);

   logic [W-1:0] cnt;

   assign busy_o = (cnt != '0);
   assign done_o = (cnt == W'(1));

   always_ff @(posedge clk_sys_i) begin
      if (!por_b_i) begin
         cnt <= '0;
      end else if (ce_i) begin
         if (start_i && !busy_o) begin
            cnt <= LOAD;
         end else if (busy_o) begin
            cnt <= cnt - W'(1);
         end
      end
   end

endmodule : spl_op_timer

// >>> bench/spl_cpu_model.sv
// CPU core model that issues store and load instruction strobes.
// Assumes the bench calls its tasks just after a rising clock edge.
module spl_cpu_model (
   input wire logic clk_sys_i,      // system clock
   output spl_pkg::spl_spm_t spm_o, // store instruction strobe
   output spl_pkg::spl_lpm_t lpm_o  // load instruction strobe
);
   timeunit 1ns;
   timeprecision 1ns;

   // No interrupt is ever taken, as if masked for the whole run.
   initial begin
      spm_o = '0;
      lpm_o = '0;
   end

   // Spare bits of the lock pattern are sent as ones while the strobe is high.
   task do_spm(input logic [7:0] r0, input int lag);
      repeat (lag) @(posedge clk_sys_i);
      spm_o <= '{exec: 1'h1, r0: {2'h3, r0[5:2], 2'h3}};
      @(posedge clk_sys_i);
      spm_o <= '{exec: 1'h0, r0: ~{2'h3, r0[5:2], 2'h3}};
   endtask : do_spm

   // The pointer shows its inverse once the strobe is over.
   task do_lpm(input logic [15:0] z, input int lag);
      repeat (lag) @(posedge clk_sys_i);
      lpm_o <= '{exec: 1'h1, z: z};
      @(posedge clk_sys_i);
      lpm_o <= '{exec: 1'h0, z: ~z};
   endtask : do_lpm

endmodule : spl_cpu_model

// >>> bench/selfprog_lock_fuse_access_test.sv
// Self-checking bench for the self-programming control block.
// Assumes spl_cpu_model as the core and a short operation length.
module selfprog_lock_fuse_access_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned OPC = 20;
   typedef struct {logic [31:0] exp; logic [31:0] mask;} spl_note_t;
   logic clk_sys_i = 1'h0;
   logic rst_b_i = 1'h0;
   logic por_b_i = 1'h0;
   logic hsel_i = 1'h0;
   logic [31:0] haddr_i = 32'h0;
   logic [1:0] htrans_i = 2'h0;
   logic hwrite_i = 1'h0;
   logic [31:0] hwdata_i = 32'h0;
   logic eeprom_write_active_i = 1'h0;
   logic [7:0] fuse_low_i;
   logic [7:0] fuse_high_i;
   logic [1:0] lock_lo_i;
   logic [31:0] hrdata_o;
   logic hreadyout_o;
   logic hresp_o;
   logic rww_block_o;
   spl_pkg::spl_spm_t spm;
   spl_pkg::spl_lpm_t lpm;
   spl_pkg::spl_lpm_rsp_t lpm_rsp_o;
   wire [31:0] lpm_seen = {23'h0, lpm_rsp_o.special, lpm_rsp_o.data};
   spl_note_t rd_q[$];
   spl_note_t lpm_q[$];
   int num_errors = 0;
   int check_count = 0;
   int seed = 96421;
   int cyc = 0;
   logic rd_pend = 1'h0;
   logic [3:0] boot_exp = 4'hf;
   logic [7:0] r0;

   spl_top #(.OP_CYCLES(OPC)) DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
      .por_b_i(por_b_i), .ce_i(1'h1), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
      .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .spm_i(spm),
      .lpm_i(lpm), .lpm_rsp_o(lpm_rsp_o),
      .eeprom_write_active_i(eeprom_write_active_i),
      .fuse_low_i(fuse_low_i), .fuse_high_i(fuse_high_i),
      .lock_lo_i(lock_lo_i), .rww_block_o(rww_block_o));

   spl_cpu_model cpu (.clk_sys_i(clk_sys_i), .spm_o(spm), .lpm_o(lpm));

   always #20 clk_sys_i = ~clk_sys_i;

   // ----------------------------------------------------------------------
   // Checking and reporting
   // ----------------------------------------------------------------------
   task chk(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task summarize();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   always @(posedge clk_sys_i) begin : watchdog
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors++;
         summarize();
      end
   end

   // A result with no note left is a mismatch by construction.
   always @(posedge clk_sys_i) begin : monitor
      spl_note_t n;
      if (rd_pend === 1'h1 && hreadyout_o === 1'h1) begin
         n = '{32'hffffffff, 32'h0};
         if (rd_q.size() > 0) n = rd_q.pop_front();
         chk("bus read", hrdata_o & n.mask, n.exp);
         chk("bus response", {31'h0, hresp_o}, 32'h0);
      end
      if (hreadyout_o === 1'h1) begin
         rd_pend <= hsel_i & htrans_i[1] & ~hwrite_i;
      end
      if (lpm_rsp_o.valid === 1'h1) begin
         n = '{32'hffffffff, 32'h0};
         if (lpm_q.size() > 0) n = lpm_q.pop_front();
         chk("load result", lpm_seen & n.mask, n.exp);
      end
   end

   // ----------------------------------------------------------------------
   // Bus and instruction helpers
   // ----------------------------------------------------------------------
   task bus(input logic wr, input logic [31:0] addr, input logic [31:0] data,
            input logic [31:0] mask);
      hsel_i <= 1'h1;
      htrans_i <= 2'h2;
      haddr_i <= addr;
      hwrite_i <= wr;
      if (!wr) rd_q.push_back('{data & mask, mask});
      do @(posedge clk_sys_i); while (hreadyout_o !== 1'h1);
      hsel_i <= 1'h0;
      htrans_i <= 2'h0;
      hwdata_i <= data;
      do @(posedge clk_sys_i); while (hreadyout_o !== 1'h1);
   endtask : bus

   task tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : tick

   task lpm_note(input logic sp, input logic [7:0] d, input logic [7:0] m);
      lpm_q.push_back('{{23'h0, sp, d & m}, {23'h0, 1'h1, m}});
   endtask : lpm_note

   task chk_block(input logic exp);
      chk("section block", {31'h0, rww_block_o}, {31'h0, exp});
   endtask : chk_block

   // Reads fuse low, lock and fuse high, one in each of the three cycles of the load window.
   task readback();
      logic [15:0] zs [3];
      logic [7:0] d;
      zs = '{spl_pkg::Z_FUSE_LO, spl_pkg::Z_LOCK, spl_pkg::Z_FUSE_HI};
      for (int i = 0; i < 3; i++) begin
         d = i == 0 ? fuse_low_i : i == 2 ? fuse_high_i :
            {2'h3, boot_exp, lock_lo_i};
         lpm_note(1'h1, d, i == 1 ? 8'h3f : 8'hff);
         bus(1'h1, spl_pkg::ADDR_CTRL, 32'h9, 32'h0);
         cpu.do_lpm(zs[i], i);
         tick(2);
         bus(1'h0, spl_pkg::ADDR_CTRL, 32'h0, 32'h1f);
      end
   endtask : readback

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      fuse_low_i <= $random(seed);
      fuse_high_i <= $random(seed);
      lock_lo_i <= $random(seed);
      repeat (16) @(posedge clk_sys_i);
      rst_b_i <= 1'h1;
      por_b_i <= 1'h1;
      @(posedge clk_sys_i);
      bus(1'h0, spl_pkg::ADDR_CTRL, 32'h0, 32'h5f);
      bus(1'h0, 32'h8, 32'h0, 32'hffffffff);
      for (int i = 0; i < 5; i++) begin
         bus(1'h1, spl_pkg::ADDR_CTRL, 32'h7 + 32'(i) * 32'h6, 32'h0);
         bus(1'h0, spl_pkg::ADDR_CTRL, 32'h0, 32'h1f);
      end
      readback();
      lpm_note(1'h0, 8'h0, 8'h0);
      cpu.do_lpm(spl_pkg::Z_LOCK, 0);
      bus(1'h1, spl_pkg::ADDR_CTRL, 32'h9, 32'h0);
      lpm_note(1'h0, 8'h0, 8'h0);
      cpu.do_lpm(spl_pkg::Z_LOCK, 4);
      bus(1'h0, spl_pkg::ADDR_CTRL, 32'h0, 32'h1f);
      eeprom_write_active_i <= 1'h1;
      bus(1'h0, spl_pkg::ADDR_STAT, 32'h4, 32'h4);
      bus(1'h1, spl_pkg::ADDR_CTRL, 32'h9, 32'h0);
      lpm_note(1'h0, 8'h0, 8'h0);
      cpu.do_lpm(spl_pkg::Z_LOCK, 0);
      bus(1'h1, spl_pkg::ADDR_CTRL, 32'h9, 32'h0);
      cpu.do_spm(8'h0, 0);
      tick(OPC);
      eeprom_write_active_i <= 1'h0;
      r0 = $random(seed);
      bus(1'h1, spl_pkg::ADDR_CTRL, 32'h9, 32'h0);
      cpu.do_spm(r0, 0);
      boot_exp = boot_exp & r0[5:2];
      tick(OPC / 2);
      chk_block(1'h0);
      bus(1'h0, spl_pkg::ADDR_STAT, 32'h2, 32'h2);
      tick(OPC);
      lock_lo_i <= ~lock_lo_i;
      readback();
      bus(1'h1, spl_pkg::ADDR_CTRL, 32'h3, 32'h0);
      cpu.do_spm($random(seed), 0);
      tick(1);
      chk_block(1'h1);
      bus(1'h1, spl_pkg::ADDR_CTRL, 32'h11, 32'h0);
      tick(1);
      chk_block(1'h1);
      bus(1'h0, spl_pkg::ADDR_CTRL, 32'h41, 32'h41);
      tick(OPC - 12);
      bus(1'h0, spl_pkg::ADDR_STAT, 32'h1, 32'h1);
      tick(6);
      bus(1'h0, spl_pkg::ADDR_STAT, 32'h0, 32'h1);
      bus(1'h0, spl_pkg::ADDR_CTRL, 32'h40, 32'h41);
      bus(1'h1, spl_pkg::ADDR_CTRL, 32'h11, 32'h0);
      tick(1);
      chk_block(1'h0);
      bus(1'h1, spl_pkg::ADDR_CTRL, 32'h5, 32'h0);
      cpu.do_spm($random(seed), 0);
      tick(2);
      rst_b_i <= 1'h0;
      tick(2);
      rst_b_i <= 1'h1;
      tick(1);
      chk_block(1'h1);
      bus(1'h0, spl_pkg::ADDR_STAT, 32'h1, 32'h1);
      tick(OPC);
      bus(1'h1, spl_pkg::ADDR_CTRL, 32'h11, 32'h0);
      tick(1);
      chk_block(1'h0);
      r0 = {2'h3, boot_exp, lock_lo_i};
      bus(1'h0, spl_pkg::ADDR_STAT, {16'h0, r0, 8'h0}, 32'hff00);
      tick(4);
      chk("notes left", 32'(rd_q.size() + lpm_q.size()), 32'h0);
      summarize();
   end

endmodule : selfprog_lock_fuse_access_test
